// file: hw/emcs_top.sv
// strobe sequencing and pin sharing for the external memory port
// assumes requests arrive synchronous to CLK and the straps are stable at reset
`timescale 1ns/1ns

// What this block does
// - port input clock picked at reset from pin, clock/4 or clock/6 by straps
// - with no other strap choice the external input clock pin is used
// - strap code 00 pin, 01 divide by four, 10 divide by six
// - divided output clock is input clock over one, two or four
// - full rate output clock runs at the selected input clock rate
// - shared read pin is async read, SDRAM column or sync strobe
// - sync space: select 0 gives address strobe, 1 gives read enable
// - shared output pin is async output enable, SDRAM row or sync enable
// - shared write pin is async, SDRAM or sync write strobe by type
// - SDRAM clock enable drives self refresh, else acts as general output
// - separate sync output enable only for the fourth space, for FIFOs
// - external async memory signals readiness on a dedicated ready input
// - exactly one chip enable per access, decoded from address bits 31:28
module emcs_top (
	input wire logic CLK,
	input wire logic RST,
	input wire logic PORT_EXT_INPUT_CLOCK,
	input wire logic [1:0] CLOCK_SELECT_STRAPS,
	input wire logic [1:0] DIVIDE_SELECT,
	output logic FULL_RATE_OUT_CLOCK,
	output logic DIVIDED_OUT_CLOCK,
	input wire logic ACC_REQ,
	input wire logic ACC_WRITE,
	input wire logic [31:0] ACC_WORD_ADDR,
	output logic ACC_READY,
	output logic ACC_DONE,
	output logic ACC_ERROR,
	input wire logic [3:0][1:0] SPACE_TYPE,
	input wire logic [3:0] READ_STROBE_SELECT,
	input wire logic ASYNC_READY_IN,
	output logic [3:0] CHIP_ENABLE_N,
	output logic SHARED_READ_STROBE_N,
	output logic SHARED_OUTPUT_STROBE_N,
	output logic SHARED_WRITE_STROBE_N,
	output logic FIFO_SPACE_OUTPUT_STROBE_N,
	input wire logic SDRAM_FITTED,
	input wire logic SELF_REFRESH_REQ,
	input wire logic GENERAL_OUT_VALUE,
	output logic SDRAM_CLK_ENABLE_OUT
);
	emcs_pkg::emcs_seq_state_t q, d;
	emcs_clk_if ck ();
	logic [3:0] hit_vec;
	logic [3:0] nib;
	logic [1:0] idx;
	logic in_strobe;
	logic is_rd;

	emcs_clkgen u_clkgen (
		.clk(CLK),
		.rst(RST),
		.ext_clk(PORT_EXT_INPUT_CLOCK),
		.straps(CLOCK_SELECT_STRAPS),
		.div_sel(DIVIDE_SELECT),
		.ck(ck)
	);

	// space decode from the top nibble of the word address
	assign nib = ACC_WORD_ADDR[emcs_pkg::CE_MSB:emcs_pkg::CE_LSB];
	assign idx = 2'(nib - emcs_pkg::CE_BASE);
	genvar gi;
	generate
		for (gi = 0; gi < emcs_pkg::NUM_SPACES; gi++) begin : g_hit
			assign hit_vec[gi] = (nib == emcs_pkg::CE_BASE + 4'(gi));
		end
	endgenerate

	// access sequencer; phases advance on port clock ticks
	always_comb begin
		d = q;
		d.done = 1'b0;
		d.err = 1'b0;
		unique case (q.st)
			emcs_pkg::ST_IDLE: begin
				if (ACC_REQ) begin
					if (|hit_vec) begin
						d.st = emcs_pkg::ST_SETUP;
						d.space = idx;
						d.mtype = emcs_pkg::emcs_mtype_t'(SPACE_TYPE[idx]);
						d.wr = ACC_WRITE;
						d.rss = READ_STROBE_SELECT[idx];
					end else begin
						d.err = 1'b1;
					end
				end
			end
			emcs_pkg::ST_SETUP: begin
				if (ck.tick) begin
					d.st = (q.mtype == emcs_pkg::MT_SDRAM) ? emcs_pkg::ST_ROW : emcs_pkg::ST_STROBE;
					d.cnt = 2'h0;
				end
			end
			emcs_pkg::ST_ROW: begin
				if (ck.tick) begin
					d.st = emcs_pkg::ST_STROBE;
				end
			end
			emcs_pkg::ST_STROBE: begin
				if (ck.tick) begin
					if (q.mtype == emcs_pkg::MT_ASYNC) begin
						if (ASYNC_READY_IN) begin
							d.st = emcs_pkg::ST_HOLD;
						end
					end else if (q.mtype == emcs_pkg::MT_SYNC && !q.wr &&
						q.cnt != emcs_pkg::SYNC_RD_LAST) begin
						d.cnt = q.cnt + 2'h1;
					end else begin
						d.st = emcs_pkg::ST_HOLD;
					end
				end
			end
			emcs_pkg::ST_HOLD: begin
				if (ck.tick) begin
					d.st = emcs_pkg::ST_IDLE;
					d.done = 1'b1;
				end
			end
		endcase
		// pin functions follow the next phase and the space's memory type
		in_strobe = (d.st == emcs_pkg::ST_STROBE);
		is_rd = !d.wr;
		d.rd_n = ~(in_strobe && ((d.mtype == emcs_pkg::MT_ASYNC && is_rd) ||
			d.mtype == emcs_pkg::MT_SDRAM ||
			(d.mtype == emcs_pkg::MT_SYNC && is_rd && (d.rss || d.cnt == 2'h0))));
		d.oe_n = ~((in_strobe && is_rd && d.mtype != emcs_pkg::MT_SDRAM) ||
			d.st == emcs_pkg::ST_ROW);
		d.we_n = ~(in_strobe && d.wr);
		d.fifo_n = ~(in_strobe && is_rd && d.mtype == emcs_pkg::MT_SYNC &&
			d.space == emcs_pkg::FIFO_SPACE);
		d.ce_n = (d.st == emcs_pkg::ST_IDLE) ? emcs_pkg::CE_NONE_N :
			~(emcs_pkg::CE_ONE << d.space);
		// clock enable: self refresh control, or a plain output with no SDRAM
		if (!SDRAM_FITTED) begin
			d.cke = GENERAL_OUT_VALUE;
		end else if (q.st == emcs_pkg::ST_IDLE) begin
			d.cke = ~SELF_REFRESH_REQ;
		end
	end

	// single state register
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			q <= emcs_pkg::SEQ_RESET;
		end else begin
			q <= d;
		end
	end

	assign ACC_READY = (q.st == emcs_pkg::ST_IDLE);
	assign ACC_DONE = q.done;
	assign ACC_ERROR = q.err;
	assign CHIP_ENABLE_N = q.ce_n;
	assign SHARED_READ_STROBE_N = q.rd_n;
	assign SHARED_OUTPUT_STROBE_N = q.oe_n;
	assign SHARED_WRITE_STROBE_N = q.we_n;
	assign FIFO_SPACE_OUTPUT_STROBE_N = q.fifo_n;
	assign SDRAM_CLK_ENABLE_OUT = q.cke;
	assign FULL_RATE_OUT_CLOCK = ck.full;
	assign DIVIDED_OUT_CLOCK = ck.divided;

	// checks on the sequencer and pins
	ce_onehot_a: assert property (@(posedge CLK) disable iff (RST)
		$onehot0(~CHIP_ENABLE_N))
		else $error("more than one chip enable low");
	ce_decode_a: assert property (@(posedge CLK) disable iff (RST)
		ACC_REQ && ACC_READY && |hit_vec |=> ~CHIP_ENABLE_N == $past(hit_vec))
		else $error("chip enable does not match address");
	async_wait_a: assert property (@(posedge CLK) disable iff (RST)
		q.st == emcs_pkg::ST_STROBE && q.mtype == emcs_pkg::MT_ASYNC && ck.tick &&
		!ASYNC_READY_IN |=> q.st == emcs_pkg::ST_STROBE && !CHIP_ENABLE_N[q.space])
		else $error("async strobe ended while not ready");
	ready_end_a: assert property (@(posedge CLK) disable iff (RST)
		q.st == emcs_pkg::ST_STROBE && q.mtype == emcs_pkg::MT_ASYNC && ck.tick &&
		ASYNC_READY_IN |=> q.st == emcs_pkg::ST_HOLD && SHARED_READ_STROBE_N &&
		SHARED_WRITE_STROBE_N)
		else $error("async strobe not ended on ready");
	ads_once_a: assert property (@(posedge CLK) disable iff (RST)
		q.st == emcs_pkg::ST_STROBE && q.mtype == emcs_pkg::MT_SYNC && !q.wr &&
		!q.rss && q.cnt == emcs_pkg::SYNC_RD_LAST |-> SHARED_READ_STROBE_N)
		else $error("address strobe held past first tick");
	re_held_a: assert property (@(posedge CLK) disable iff (RST)
		q.st == emcs_pkg::ST_STROBE && q.mtype == emcs_pkg::MT_SYNC && !q.wr &&
		q.rss |-> !SHARED_READ_STROBE_N && !SHARED_OUTPUT_STROBE_N)
		else $error("read enable not held through strobe");
	fifo_space_a: assert property (@(posedge CLK) disable iff (RST)
		!FIFO_SPACE_OUTPUT_STROBE_N |-> !CHIP_ENABLE_N[emcs_pkg::FIFO_SPACE])
		else $error("fifo output enable outside its space");
	row_strobe_a: assert property (@(posedge CLK) disable iff (RST)
		q.st == emcs_pkg::ST_ROW |-> !SHARED_OUTPUT_STROBE_N && SHARED_READ_STROBE_N)
		else $error("row strobe missing in row phase");
	write_pin_a: assert property (@(posedge CLK) disable iff (RST)
		q.st == emcs_pkg::ST_STROBE && q.wr |-> !SHARED_WRITE_STROBE_N)
		else $error("write strobe missing");
	cke_gpo_a: assert property (@(posedge CLK) disable iff (RST)
		!SDRAM_FITTED |=> SDRAM_CLK_ENABLE_OUT == $past(GENERAL_OUT_VALUE))
		else $error("clock enable not following general output");
	err_no_ce_a: assert property (@(posedge CLK) disable iff (RST)
		ACC_ERROR |-> CHIP_ENABLE_N == emcs_pkg::CE_NONE_N)
		else $error("chip enable driven on an unmapped request");
	sdram_col_a: assert property (@(posedge CLK) disable iff (RST)
		q.st == emcs_pkg::ST_STROBE && q.mtype == emcs_pkg::MT_SDRAM |->
		!SHARED_READ_STROBE_N && SHARED_OUTPUT_STROBE_N)
		else $error("column strobe missing in SDRAM strobe phase");
	refresh_idle_a: assert property (@(posedge CLK) disable iff (RST)
		SDRAM_FITTED && ACC_READY && !$past(RST) |=>
		SDRAM_CLK_ENABLE_OUT == ~$past(SELF_REFRESH_REQ))
		else $error("clock enable not following self refresh request");

	async_wait_cov: cover property (@(posedge CLK) disable iff (RST)
		q.st == emcs_pkg::ST_STROBE && q.mtype == emcs_pkg::MT_ASYNC && ck.tick &&
		!ASYNC_READY_IN);
	sdram_cov: cover property (@(posedge CLK) disable iff (RST)
		q.st == emcs_pkg::ST_ROW ##[1:40] ACC_DONE);
	fifo_cov: cover property (@(posedge CLK) disable iff (RST)
		!FIFO_SPACE_OUTPUT_STROBE_N);
	err_cov: cover property (@(posedge CLK) disable iff (RST)
		ACC_ERROR);
endmodule

// file: hw/emcs_pkg.sv
// constants and state types for the external memory port clock and strobe block
// assumes one 100 MHz system clock; everything else is derived from enables
package emcs_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// clock source codes caught from the straps at reset release
	localparam logic [1:0] SRC_EXT = 2'h0;
	localparam logic [1:0] SRC_DIV4 = 2'h1;
	localparam logic [1:0] SRC_DIV6 = 2'h2;
	// half periods of the internally divided sources, in system cycles
	localparam logic [2:0] DIV4_HALF = 3'h2;
	localparam logic [2:0] DIV6_HALF = 3'h3;
	// divide factor codes for the divided output clock
	localparam logic [1:0] DIVF_1 = 2'h0;
	localparam logic [1:0] DIVF_2 = 2'h1;
	localparam logic [1:0] DIVF_4 = 2'h2;
	localparam logic [1:0] MASK_1 = 2'h0;
	localparam logic [1:0] MASK_2 = 2'h1;
	localparam logic [1:0] MASK_4 = 2'h3;
	localparam logic [1:0] DIV4_HIGH_RISES = 2'h2;
	// chip enable decode on the word address
	localparam int CE_MSB = 31;
	localparam int CE_LSB = 28;
	localparam int NUM_SPACES = 4;
	localparam logic [3:0] CE_BASE = 4'h8;
	localparam logic [1:0] FIFO_SPACE = 2'h3;
	localparam logic [1:0] SYNC_RD_LAST = 2'h1;
	localparam logic [3:0] CE_NONE_N = 4'hF;
	localparam logic [3:0] CE_ONE = 4'h1;

	typedef enum logic [1:0] {MT_ASYNC, MT_SDRAM, MT_SYNC, MT_RSVD} emcs_mtype_t;
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_ROW, ST_STROBE, ST_HOLD} emcs_state_t;

	typedef struct packed {
		logic strap_taken;
		logic [1:0] src;
		logic ext_prev;
		logic [2:0] cnt;
		logic full;
		logic [1:0] rcnt;
		logic [1:0] divf;
		logic divided;
		logic tick;
	} emcs_clk_state_t;

	typedef struct packed {
		emcs_state_t st;
		logic [1:0] space;
		emcs_mtype_t mtype;
		logic wr;
		logic rss;
		logic [1:0] cnt;
		logic [3:0] ce_n;
		logic rd_n;
		logic oe_n;
		logic we_n;
		logic fifo_n;
		logic cke;
		logic done;
		logic err;
	} emcs_seq_state_t;

	localparam emcs_clk_state_t CLK_RESET = '{src: SRC_EXT, divf: DIVF_1, default: '0};
	localparam emcs_seq_state_t SEQ_RESET = '{st: ST_IDLE, space: 2'h0, mtype: MT_ASYNC,
		ce_n: CE_NONE_N, rd_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, fifo_n: 1'b1, default: '0};
endpackage

// file: hw/emcs_clk_if.sv
// port clock signals passed from the clock generator to the strobe sequencer
// assumes both ends run on the same system clock
`timescale 1ns/1ns
interface emcs_clk_if;
	logic tick;
	logic full;
	logic divided;
	logic [1:0] src;
	modport gen (output tick, output full, output divided, output src);
	modport use_side (input tick, input full, input divided, input src);
endinterface

// file: hw/emcs_clkgen.sv
// port input clock selection and the two output clocks
// assumes the external clock pin is sampled as a synchronous level
`timescale 1ns/1ns
module emcs_clkgen (
	input wire logic clk,
	input wire logic rst,
	input wire logic ext_clk,
	input wire logic [1:0] straps,
	input wire logic [1:0] div_sel,
	emcs_clk_if.gen ck
);
	emcs_pkg::emcs_clk_state_t q, d;
	logic [2:0] half;
	logic [1:0] mask;
	logic [1:0] rnext;

	// source, output clock and divider next state
	always_comb begin
		d = q;
		half = (q.src == emcs_pkg::SRC_DIV4) ? emcs_pkg::DIV4_HALF : emcs_pkg::DIV6_HALF;
		mask = (q.divf == emcs_pkg::DIVF_4) ? emcs_pkg::MASK_4 :
			(q.divf == emcs_pkg::DIVF_2) ? emcs_pkg::MASK_2 : emcs_pkg::MASK_1;
		rnext = (q.rcnt + 2'h1) & mask;
		d.ext_prev = ext_clk;
		// straps caught once, just after reset release; 11 falls back to the pin
		if (!q.strap_taken) begin
			d.strap_taken = 1'b1;
			unique case (straps)
				emcs_pkg::SRC_DIV4: d.src = emcs_pkg::SRC_DIV4;
				emcs_pkg::SRC_DIV6: d.src = emcs_pkg::SRC_DIV6;
				default: d.src = emcs_pkg::SRC_EXT;
			endcase
		end
		// full rate clock: the pin itself or a square wave from the counter
		if (q.src == emcs_pkg::SRC_EXT) begin
			d.full = ext_clk;
			d.cnt = 3'h0;
		end else if (q.cnt + 3'h1 >= half) begin
			d.full = ~q.full;
			d.cnt = 3'h0;
		end else begin
			d.cnt = q.cnt + 3'h1;
		end
		d.tick = d.full & ~q.full;
		// divided clock by two or four moves only on a full rate rise; by one it follows the full rate clock; factor taken at period start
		if (d.tick) begin
			d.rcnt = rnext;
			if (rnext == 2'h0) begin
				d.divf = div_sel;
				d.rcnt = 2'h0;
			end
			if (d.divf == emcs_pkg::DIVF_4) begin
				d.divided = (d.rcnt < emcs_pkg::DIV4_HIGH_RISES);
			end else if (d.divf == emcs_pkg::DIVF_2) begin
				d.divided = (d.rcnt == 2'h0);
			end
		end
		if (d.divf == emcs_pkg::DIVF_1) begin
			d.divided = d.full;
		end
	end

	// single state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= emcs_pkg::CLK_RESET;
		end else begin
			q <= d;
		end
	end

	assign ck.tick = q.tick;
	assign ck.full = q.full;
	assign ck.divided = q.divided;
	assign ck.src = q.src;

	strap_hold_a: assert property (@(posedge clk) disable iff (rst)
		q.strap_taken && $past(q.strap_taken) |-> $stable(q.src))
		else $error("clock source changed after reset");
	ext_follow_a: assert property (@(posedge clk) disable iff (rst)
		q.strap_taken && q.src == emcs_pkg::SRC_EXT |=> q.full == $past(ext_clk))
		else $error("full rate clock does not follow the pin");
	div_clean_a: assert property (@(posedge clk) disable iff (rst)
		$changed(q.divided) && q.divf != emcs_pkg::DIVF_1 |-> $rose(q.full))
		else $error("divided clock moved off a full rate rise");
	div4_cov: cover property (@(posedge clk) disable iff (rst)
		q.divf == emcs_pkg::DIVF_4 && $rose(q.divided));
endmodule

// file: testbench/emcs_async_mem.sv
// asynchronous memory model answering on the ready input of space 0
// assumes tick is the full rate port clock and strobe_n is low while strobed
`timescale 1ns/1ns
module emcs_async_mem (
	input wire logic clk,
	input wire logic rst,
	input wire logic tick,
	input wire logic strobe_n,
	input wire logic [3:0] wait_ticks,
	output logic ready
);
	logic tick_q;
	logic [3:0] cnt_q;
	// count port clock rises while the access is strobed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_q <= 1'b0;
			cnt_q <= 4'h0;
		end else begin
			tick_q <= tick;
			if (strobe_n)
				cnt_q <= 4'h0;
			else if (tick && !tick_q && cnt_q != 4'hF)
				cnt_q <= cnt_q + 4'h1;
		end
	end
	// not ready until the wait has run out; pulled up when not strobed
	assign ready = strobe_n || (cnt_q >= wait_ticks);
endmodule

// file: testbench/testbench.sv
// self-checking bench for the port clock and strobe block
// assumes spaces 0 async, 1 SDRAM, 2 and 3 sync; space 3 uses read enable
`timescale 1ns/1ns
module testbench;
	logic clk, rst, ext_clk, req, wr, ardy, fit, srq, gov, mon, multi, err_seen;
	logic fclk, dclk, rdy, done, err, rd_n, oe_n, we_n, fifo_n, cke;
	logic [1:0] straps, divs;
	logic [31:0] addr;
	logic [3:0] wait_t, ce_n, ce_seen;
	int errors, samples_checked, ext_cnt, rd_len, oe_len, we_len, fifo_len, len_a, p, i;
	logic [1:0] t_s [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
	int t_p [4] = '{10, 10, 6, 4};
	logic [3:0] t_k [4] = '{4'hC, 4'h9, 4'h3, 4'h4};
	logic [31:0] t_a [8] = '{32'h80000010, 32'h80000010, 32'h90000000, 32'h90000000,
		32'hA0000000, 32'hB0000000, 32'hB0000000, 32'h10000000};
	logic [7:0] t_w = 8'h4A;
	logic [11:0] t_c [8] = '{12'hECF, 12'hE2B, 12'hDCF, 12'hDEF, 12'hBCF, 12'h7DF, 12'h723,
		12'hF0F};

	emcs_top DUT (.CLK(clk), .RST(rst), .PORT_EXT_INPUT_CLOCK(ext_clk),
		.CLOCK_SELECT_STRAPS(straps), .DIVIDE_SELECT(divs), .FULL_RATE_OUT_CLOCK(fclk),
		.DIVIDED_OUT_CLOCK(dclk), .ACC_REQ(req), .ACC_WRITE(wr), .ACC_WORD_ADDR(addr),
		.ACC_READY(rdy), .ACC_DONE(done), .ACC_ERROR(err),
		.SPACE_TYPE({emcs_pkg::MT_SYNC, emcs_pkg::MT_SYNC, emcs_pkg::MT_SDRAM, emcs_pkg::MT_ASYNC}),
		.READ_STROBE_SELECT(4'h8), .ASYNC_READY_IN(ardy), .CHIP_ENABLE_N(ce_n),
		.SHARED_READ_STROBE_N(rd_n), .SHARED_OUTPUT_STROBE_N(oe_n),
		.SHARED_WRITE_STROBE_N(we_n), .FIFO_SPACE_OUTPUT_STROBE_N(fifo_n),
		.SDRAM_FITTED(fit), .SELF_REFRESH_REQ(srq), .GENERAL_OUT_VALUE(gov),
		.SDRAM_CLK_ENABLE_OUT(cke));

	emcs_async_mem MEM (.clk(clk), .rst(rst), .tick(fclk), .strobe_n((rd_n & we_n) | ce_n[0]),
		.wait_ticks(wait_t), .ready(ardy));

	// system clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// external port clock pin, ten cycle period
	always @(posedge clk) begin
		if (ext_cnt == 4) begin
			ext_cnt <= 0;
			ext_clk <= !ext_clk;
		end else
			ext_cnt <= ext_cnt + 1;
	end

	// strobe and chip enable monitor during an access
	always @(posedge clk) begin
		if (mon) begin
			rd_len += (rd_n === 1'b0);
			oe_len += (oe_n === 1'b0);
			we_len += (we_n === 1'b0);
			fifo_len += (fifo_n === 1'b0);
			ce_seen &= ce_n;
			if ($countones(~ce_n) > 1)
				multi = 1'b1;
			if (err === 1'b1)
				err_seen = 1'b1;
		end
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic do_reset(input logic [1:0] s);
		rst <= 1'b1;
		straps <= s;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		#1 chk("idle_pins", 16'h01FF, {rd_n, oe_n, we_n, fifo_n, ce_n, rdy});
	endtask

	// clock period in system cycles between two rises
	task automatic period(input bit d, output int per);
		logic pv, cv;
		int n, t0;
		per = 0;
		t0 = -1;
		pv = d ? dclk : fclk;
		for (n = 0; n < 200 && per == 0; n++) begin
			@(posedge clk);
			cv = d ? dclk : fclk;
			if (cv === 1'b1 && pv === 1'b0) begin
				if (t0 < 0)
					t0 = n;
				else
					per = n - t0;
			end
			pv = cv;
		end
	endtask

	task automatic access(input logic [31:0] a, input logic w);
		int n;
		rd_len = 0;
		oe_len = 0;
		we_len = 0;
		fifo_len = 0;
		ce_seen = 4'hF;
		multi = 1'b0;
		err_seen = 1'b0;
		@(posedge clk);
		req <= 1'b1;
		addr <= a;
		wr <= w;
		mon <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		for (n = 0; n < 400; n++) begin
			@(posedge clk);
			if (done === 1'b1 || err === 1'b1)
				break;
		end
		mon <= 1'b0;
		// one more edge so the monitor has surely taken the closing edge
		@(posedge clk);
		chk("finished", 16'h1, n < 400);
	endtask

	task automatic test_done;
		if (errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watchdog against a hung handshake
	initial begin
		#200000;
		errors++;
		test_done;
	end

	initial begin
		rst = 1'b1;
		ext_clk = 1'b0;
		ext_cnt = 0;
		req = 1'b0;
		wr = 1'b0;
		addr = 32'h0;
		straps = 2'h0;
		divs = 2'h0;
		fit = 1'b1;
		srq = 1'b0;
		gov = 1'b0;
		wait_t = 4'h0;
		mon = 1'b0;
		errors = 0;
		samples_checked = 0;
		// source selection by straps, divide by one
		for (i = 0; i < 4; i++) begin
			do_reset(t_s[i]);
			period(0, p);
			chk("full_clk", t_p[i], p);
			period(1, p);
			chk("div_clk", t_p[i], p);
		end
		// divide by two and four on the clock/4 source
		for (i = 1; i < 3; i++) begin
			divs <= i[1:0];
			repeat (40) @(posedge clk);
			period(1, p);
			chk("div_clk", 16'(4 << i), p);
			period(1, p);
			chk("div_steady", 16'(4 << i), p);
		end
		divs <= 2'h0;
		// clock enable: self refresh and general output
		for (i = 0; i < 4; i++) begin
			fit <= t_k[i][3];
			srq <= t_k[i][2];
			gov <= t_k[i][1];
			repeat (5) @(posedge clk);
			#1 chk("clk_enable", t_k[i][0], cke);
		end
		// a read and a write on spaces 0, 1 and 3, a read on space 2, then an unmapped address
		for (i = 0; i < 8; i++) begin
			access(t_a[i], t_w[i]);
			chk("chip_enable", t_c[i][11:8], ce_seen);
			chk("one_enable", 16'h0, multi);
			chk("error", i == 7, err_seen);
			chk("strobes", t_c[i][7:4] & t_c[i][3:0], {rd_len > 0, oe_len > 0, we_len > 0,
				fifo_len > 0} & t_c[i][3:0]);
			if (i == 4)
				len_a = rd_len;
			if (i == 5)
				chk("read_len", 16'(2 * len_a), 16'(rd_len));
		end
		// async strobe stretched by a slow memory
		access(32'h80000000, 1'b0);
		len_a = rd_len;
		wait_t <= 4'h3;
		access(32'h80000000, 1'b0);
		chk("stretch", 16'h1, rd_len >= len_a + 8);
		test_done;
	end
endmodule
